// ### rtl/adc_ctl.sv
`timescale 1ns/1ns
module adc_ctl import adc_ctl_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata_q,
  input wire logic timer_sample_clock,
  input wire logic timer_underflow,
  input wire logic ext_trigger_pin_n,
  input wire logic conv_done,
  input wire logic [11:0] conv_data,
  output logic sample_en_q,
  output logic conv_start_q,
  output logic [2:0] conv_ch_q,
  output logic busy_q,
  output logic irq_q
);
  // ****************************************
  // registers
  // ****************************************
  logic en_q;
  logic start_q;
  logic [15:0] trg_q;
  logic [1:0] range_q;
  logic [15:0] intf_q;
  logic [15:0] inte_q;
  logic ext_q;
  seq_state_t state_q;
  seq_state_t state_d;
  logic [2:0] ch_d;

  wire wr_ctl = reg_wr && reg_addr == ADDR_CTL;
  wire wr_trg = reg_wr && reg_addr == ADDR_TRG;
  wire wr_cfg = reg_wr && reg_addr == ADDR_CFG;
  wire wr_intf = reg_wr && reg_addr == ADDR_INTF;
  wire wr_inte = reg_wr && reg_addr == ADDR_INTE;

  wire [2:0] smp_sel = trg_q[TRG_SMP_LSB +: 3];
  wire [1:0] src_sel = trg_q[TRG_SRC_LSB +: 2];
  wire repeat_on = trg_q[TRG_REPEAT_BIT];
  wire align_left = trg_q[TRG_ALIGN_BIT];
  wire [2:0] first_ch = trg_q[TRG_FIRST_LSB +: 3];
  wire [2:0] last_ch = trg_q[TRG_LAST_LSB +: 3];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      en_q <= 1'b0;
      start_q <= 1'b0;
      trg_q <= TRG_RESET;
      range_q <= 2'h0;
      inte_q <= 16'h0000;
    end else begin
      if (wr_ctl) begin
        en_q <= reg_wdata[CTL_EN_BIT];
        start_q <= reg_wdata[CTL_START_BIT];
      end
      if (wr_trg) begin
        trg_q <= reg_wdata & TRG_WMASK;
      end
      if (wr_cfg) begin
        range_q <= reg_wdata[1:0];
      end
      if (wr_inte) begin
        inte_q <= reg_wdata;
      end
    end
  end

  // ****************************************
  // trigger selection
  // ****************************************
  // the pin is taken as synchronous; only its falling edge counts
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ext_q <= 1'b1;
    end else begin
      ext_q <= ext_trigger_pin_n;
    end
  end

  wire ext_fall = ext_q && !ext_trigger_pin_n;
  wire soft_go = wr_ctl && reg_wdata[CTL_START_BIT] && !start_q;
  wire can_run = en_q && range_q == RANGE_ON;
  wire trig_evt = (src_sel == SRC_SOFT && soft_go) ||
                  (src_sel == SRC_TIMER && start_q && timer_underflow) ||
                  (src_sel == SRC_EXT && start_q && ext_fall);

  // ****************************************
  // sequencer
  // ****************************************
  logic smp_done;
  wire keep_going = start_q && can_run;
  wire at_last = conv_ch_q == last_ch;

  always_comb begin
    state_d = state_q;
    ch_d = conv_ch_q;
    unique case (state_q)
      ST_IDLE: begin
        if (can_run && trig_evt) begin
          state_d = ST_SAMPLE;
          ch_d = first_ch;
        end
      end
      ST_SAMPLE: begin
        if (smp_done) begin
          state_d = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        // overwrite errors never stop the pass
        if (conv_done) begin
          if (at_last && repeat_on && keep_going) begin
            state_d = ST_SAMPLE;
            ch_d = first_ch;
          end else if (!at_last && keep_going) begin
            state_d = ST_SAMPLE;
            ch_d = conv_ch_q + 3'h1;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  wire go_sample = state_d == ST_SAMPLE && (state_q != ST_SAMPLE);
  wire load = state_q == ST_CONVERT && conv_done;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      conv_ch_q <= 3'h0;
      sample_en_q <= 1'b0;
      conv_start_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      conv_ch_q <= ch_d;
      sample_en_q <= state_d == ST_SAMPLE;
      conv_start_q <= state_q == ST_SAMPLE && smp_done;
      busy_q <= state_d != ST_IDLE;
    end
  end

  adc_sample_timer u_timer (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .start(go_sample),
    .tick(timer_sample_clock),
    .sel(smp_sel),
    .done_q(smp_done)
  );

  // ****************************************
  // flags and interrupt
  // ****************************************
  wire [7:0] load_hot = load ? 8'(8'h01 << conv_ch_q) : 8'h00;
  wire [15:0] flag_set = {load_hot & intf_q[7:0], load_hot};
  wire [15:0] flag_clr = wr_intf ? reg_wdata : 16'h0000;
  // a load in the clearing cycle wins over the clear
  wire [15:0] intf_d = (intf_q & ~flag_clr) | flag_set;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      intf_q <= 16'h0000;
      irq_q <= 1'b0;
    end else begin
      intf_q <= intf_d;
      irq_q <= |(intf_d & inte_q);
    end
  end

  // ****************************************
  // results and read path
  // ****************************************
  logic [15:0] res_value;

  adc_result_bank u_bank (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .load(load),
    .load_idx(conv_ch_q),
    .load_data(conv_data),
    .rd_idx(reg_addr[2:0]),
    .align_left(align_left),
    .rd_value(res_value)
  );

  wire [15:0] ctl_view = 16'({1'b0, conv_ch_q, 1'b0, busy_q, 8'h00, start_q, en_q});
  wire [15:0] rd_mux = is_result_addr(reg_addr) ? res_value :
                       reg_addr == ADDR_CTL ? ctl_view :
                       reg_addr == ADDR_TRG ? trg_q :
                       reg_addr == ADDR_CFG ? {14'h0000, range_q} :
                       reg_addr == ADDR_INTF ? intf_q :
                       reg_addr == ADDR_INTE ? inte_q : 16'h0000;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_q <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata_q <= rd_mux;
    end else begin
      reg_rdata_q <= 16'h0000;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_left_low_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reg_rd && is_result_addr(reg_addr) && align_left |=> reg_rdata_q[3:0] == 4'h0)
    else $error("left justified low nibble not zero");

  a_right_high_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reg_rd && is_result_addr(reg_addr) && !align_left |=> reg_rdata_q[15:12] == 4'h0)
    else $error("right justified high nibble not zero");

  // mux value at the read edge, to judge the registered answer
  logic [15:0] rd_mux_past;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_mux_past <= 16'h0000;
    end else begin
      rd_mux_past <= rd_mux;
    end
  end

  a_align_same_value: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reg_rd && is_result_addr(reg_addr) |=> reg_rdata_q ==
    ($past(align_left) ? {rd_mux_past[15:4], 4'h0} : {4'h0, rd_mux_past[11:0]}))
    else $error("aligned read wrong");

  a_trg_reserved: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reg_rd && reg_addr == ADDR_TRG |=> (reg_rdata_q & ~TRG_WMASK) == 16'h0000)
    else $error("reserved trigger bits not zero");

  a_cfg_reserved: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reg_rd && reg_addr == ADDR_CFG |=> reg_rdata_q[15:2] == 14'h0000)
    else $error("reserved configuration bits not zero");

  a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reg_rd && !is_result_addr(reg_addr) && reg_addr > ADDR_INTE |=> reg_rdata_q == 16'h0000)
    else $error("unmapped index read not zero");

  a_inte_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_inte |=> inte_q == $past(reg_wdata))
    else $error("enable register write lost");

  // ****************************************
  // sequencer checks
  // ****************************************
  a_range_blocks: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state_q == ST_IDLE && range_q != RANGE_ON |=> state_q == ST_IDLE)
    else $error("conversion started while range disabled");

  a_reserved_src: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state_q == ST_IDLE && src_sel == 2'h2 |=> state_q == ST_IDLE)
    else $error("reserved trigger started a conversion");

  a_soft_start: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state_q == ST_IDLE && can_run && src_sel == SRC_SOFT && soft_go |=> state_q == ST_SAMPLE)
    else $error("software start ignored");

  a_timer_start: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state_q == ST_IDLE && can_run && src_sel == SRC_TIMER && start_q && timer_underflow
    |=> state_q == ST_SAMPLE)
    else $error("timer underflow ignored");

  a_ext_start: assert property (@(posedge clk_sys) disable iff (!reset_n)
    state_q == ST_IDLE && can_run && src_sel == SRC_EXT && start_q && ext_fall
    |=> state_q == ST_SAMPLE)
    else $error("external trigger ignored");

  a_sample_then_conv: assert property (@(posedge clk_sys) disable iff (!reset_n)
    conv_start_q |-> !sample_en_q && state_q == ST_CONVERT)
    else $error("conversion started while sampling");

  a_first_input: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(busy_q) |-> conv_ch_q == $past(first_ch))
    else $error("pass did not begin at first input");

  a_next_input: assert property (@(posedge clk_sys) disable iff (!reset_n)
    load && !at_last && keep_going |=> conv_ch_q == $past(conv_ch_q) + 3'h1)
    else $error("pass skipped an input");

  a_overrun_continues: assert property (@(posedge clk_sys) disable iff (!reset_n)
    load && intf_q[conv_ch_q] && keep_going && (!at_last || repeat_on)
    |=> state_q == ST_SAMPLE)
    else $error("overwrite error stopped conversion");

  // ****************************************
  // flag, interrupt and one-pass checks
  // ****************************************

  a_done_flag_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
    load |=> intf_q[$past(conv_ch_q)])
    else $error("completion flag not set on load");

  a_overwrite_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
    load && intf_q[conv_ch_q] |=> intf_q[8 + $past(conv_ch_q)])
    else $error("overwrite flag not set");

  a_w1c_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_intf && reg_wdata[15] && !load |=> !intf_q[15])
    else $error("flag not cleared by writing 1");

  a_irq_gated: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (intf_q & inte_q) == 16'h0000 && !load |=> !irq_q)
    else $error("interrupt without enabled flag");

  a_w1c_zero_keeps: assert property (@(posedge clk_sys) disable iff (!reset_n)
    wr_intf && reg_wdata == 16'h0000 && !load |=> intf_q == $past(intf_q))
    else $error("writing 0 changed a flag");

  a_done_only_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !load |=> (intf_q[7:0] & ~$past(intf_q[7:0])) == 8'h00)
    else $error("completion flag set without load");

  a_irq_follows: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (intf_q & inte_q) != 16'h0000 && !wr_intf && !wr_inte |=> irq_q)
    else $error("enabled flag raised no interrupt");

  a_one_pass_ends: assert property (@(posedge clk_sys) disable iff (!reset_n)
    load && at_last && !repeat_on |=> state_q == ST_IDLE)
    else $error("one-time pass did not stop");

  // ****************************************
  // coverage
  // ****************************************
  c_one_pass: cover property (@(posedge clk_sys) disable iff (!reset_n)
    load && at_last && !repeat_on);
  c_overwrite: cover property (@(posedge clk_sys) disable iff (!reset_n)
    load && intf_q[conv_ch_q]);
  c_ext_start: cover property (@(posedge clk_sys) disable iff (!reset_n)
    state_q == ST_IDLE && src_sel == SRC_EXT ##1 state_q == ST_SAMPLE);
  c_timer_start: cover property (@(posedge clk_sys) disable iff (!reset_n)
    state_q == ST_IDLE && src_sel == SRC_TIMER ##1 state_q == ST_SAMPLE);
  c_repeat_wrap: cover property (@(posedge clk_sys) disable iff (!reset_n)
    load && at_last && repeat_on && keep_going);
endmodule // adc_ctl

// ### rtl/adc_ctl_pkg.sv
// Contract
// - alignment select 1 gives left justified reads, 0 right; applies at once
// - left justified: result in bits 15..4, bits 3..0 zero
// - right justified: result in bits 11..0, bits 15..12 zero
// - alignment only changes presentation, stored values stay untouched
// - repeat select 1 converts continuously, 0 makes one pass
// - trigger 3 external pin, 1 timer underflow, 0 software start, 2 reserved
// - sampling lasts select value plus four timer clocks
// - range 0 blocks conversion, 3 enables, 1 and 2 reserved
// - flags: overwrite errors in 15..8, completions in 7..0
// - writing 1 clears a flag, writing 0 leaves it
// - enables mirror flag layout, 1 enables
// - each input has a read-only 16-bit result, zero after reset
// - completion sets on load; overwrite sets if loaded while completion set
// - conversion keeps running after an overwrite error
// - interrupt request only while an enabled flag is set
package adc_ctl_pkg;
  // ****************************************
  // register map, word indices
  // ****************************************
  localparam logic [3:0] ADDR_CTL = 4'h0;
  localparam logic [3:0] ADDR_TRG = 4'h1;
  localparam logic [3:0] ADDR_CFG = 4'h2;
  localparam logic [3:0] ADDR_INTF = 4'h3;
  localparam logic [3:0] ADDR_INTE = 4'h4;
  localparam logic [3:0] ADDR_RES_BASE = 4'h8;
  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_START_BIT = 1;
  localparam int CTL_BUSY_BIT = 10;
  localparam int CTL_CUR_LSB = 12;
  localparam int TRG_SMP_LSB = 0;
  localparam int TRG_SRC_LSB = 4;
  localparam int TRG_REPEAT_BIT = 6;
  localparam int TRG_ALIGN_BIT = 7;
  localparam int TRG_FIRST_LSB = 8;
  localparam int TRG_LAST_LSB = 11;
  localparam logic [15:0] TRG_WMASK = 16'h3FF7;
  localparam logic [15:0] TRG_RESET = 16'h0007;
  localparam logic [15:0] CFG_WMASK = 16'h0003;
  localparam logic [1:0] RANGE_ON = 2'h3;
  localparam logic [1:0] SRC_SOFT = 2'h0;
  localparam logic [1:0] SRC_TIMER = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h3;
  localparam logic [3:0] SMP_BASE = 4'h4;
  localparam int NUM_IN = 8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10
  } seq_state_t;

  function automatic logic [15:0] align_result(input logic [11:0] v, input logic left);
    align_result = left ? {v, 4'h0} : {4'h0, v};
  endfunction

  function automatic logic is_result_addr(input logic [3:0] a);
    is_result_addr = a[3];
  endfunction
endpackage

// ### rtl/adc_result_bank.sv
`timescale 1ns/1ns
module adc_result_bank import adc_ctl_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [2:0] load_idx,
  input wire logic [11:0] load_data,
  input wire logic [2:0] rd_idx,
  input wire logic align_left,
  output logic [15:0] rd_value
);
  // raw values kept, alignment applied only on the read path
  logic [11:0] mem_q [NUM_IN];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_IN; i++) begin
        mem_q[i] <= 12'h000;
      end
    end else if (load) begin
      mem_q[load_idx] <= load_data;
    end
  end

  assign rd_value = align_result(mem_q[rd_idx], align_left);
endmodule // adc_result_bank

// ### rtl/adc_sample_timer.sv
`timescale 1ns/1ns
module adc_sample_timer import adc_ctl_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic start,
  input wire logic tick,
  input wire logic [2:0] sel,
  output logic done_q
);
  logic [3:0] cnt_q;
  logic run_q;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= 4'h0;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        cnt_q <= {1'b0, sel} + SMP_BASE;
        run_q <= 1'b1;
      end else if (run_q && tick) begin
        cnt_q <= cnt_q - 4'h1;
        if (cnt_q == 4'h1) begin
          run_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  // helper: ticks seen since start
  logic [3:0] seen_q;
  logic [3:0] want_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      seen_q <= 4'h0;
      want_q <= 4'h0;
    end else if (start) begin
      seen_q <= 4'h0;
      want_q <= {1'b0, sel} + SMP_BASE;
    end else if (run_q && tick) begin
      seen_q <= seen_q + 4'h1;
    end
  end

  a_sample_length: assert property (@(posedge clk_sys) disable iff (!reset_n)
    done_q |-> seen_q == want_q) else $error("sampling length wrong");
endmodule // adc_sample_timer

// ### testbench/adc_core_model.sv
`timescale 1ns/1ns
// ****************************************
// analog core and sampling timer model
// ****************************************
module adc_core_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic sample_en_q,
  input wire logic conv_start_q,
  input wire logic [2:0] conv_ch_q,
  input wire logic slow,
  output logic timer_sample_clock,
  output logic conv_done,
  output logic [11:0] conv_data,
  output logic [3:0] ticks_q
);
  logic [1:0] div_q;
  logic [3:0] wait_q;
  logic [3:0] run_q;
  logic [2:0] ch_q;
  logic busy_q;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 2'h0;
      wait_q <= 4'h0;
      run_q <= 4'h0;
      ch_q <= 3'h0;
      busy_q <= 1'b0;
      ticks_q <= 4'h0;
      conv_done <= 1'b0;
      conv_data <= 12'h000;
      timer_sample_clock <= 1'b0;
    end else begin
      div_q <= div_q + 2'h1;
      timer_sample_clock <= (div_q == 2'h3);
      conv_done <= 1'b0;
      if (sample_en_q && timer_sample_clock) begin
        run_q <= run_q + 4'h1;
      end
      if (conv_start_q) begin
        ticks_q <= run_q;
        run_q <= 4'h0;
        busy_q <= 1'b1;
        ch_q <= conv_ch_q;
        wait_q <= slow ? 4'h7 : 4'h1;
      end else if (busy_q && wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
        conv_data <= ~conv_data;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        conv_done <= 1'b1;
        conv_data <= 12'hA50 + {9'h000, ch_q};
      end else begin
        // data is only meaningful beside conv_done
        conv_data <= ~conv_data;
      end
    end
  end
endmodule // adc_core_model

// ### testbench/tb_adc_config_irq_result_regs.sv
`timescale 1ns/1ns
module tb_adc_config_irq_result_regs import adc_ctl_pkg::*;;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic timer_underflow = 1'b0;
  logic ext_trigger_pin_n = 1'b1;
  logic slow = 1'b0;
  logic [15:0] reg_rdata_q;
  logic timer_sample_clock;
  logic conv_done;
  logic [11:0] conv_data;
  logic sample_en_q;
  logic conv_start_q;
  logic [2:0] conv_ch_q;
  logic busy_q;
  logic irq_q;
  logic [3:0] ticks_q;
  logic [15:0] v;
  int failures = 0;
  int cmp_count = 0;
  // ****************************************
  // instances
  // ****************************************
  adc_ctl i_adc_ctl (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .timer_sample_clock(timer_sample_clock), .timer_underflow(timer_underflow),
    .ext_trigger_pin_n(ext_trigger_pin_n), .conv_done(conv_done), .conv_data(conv_data),
    .sample_en_q(sample_en_q), .conv_start_q(conv_start_q), .conv_ch_q(conv_ch_q),
    .busy_q(busy_q), .irq_q(irq_q));
  adc_core_model i_adc_core_model (.clk_sys(clk_sys), .reset_n(reset_n),
    .sample_en_q(sample_en_q), .conv_start_q(conv_start_q), .conv_ch_q(conv_ch_q),
    .slow(slow), .timer_sample_clock(timer_sample_clock), .conv_done(conv_done),
    .conv_data(conv_data), .ticks_q(ticks_q));
  // ****************************************
  // bus tasks and checks
  // ****************************************
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  function automatic logic [11:0] res(input int m);
    res = 12'hA50 + m[11:0];
  endfunction
  function automatic logic [15:0] trg(input logic [2:0] l, f, input logic al, rp,
      input logic [1:0] src, input logic [2:0] smp);
    trg = {2'h0, l, f, al, rp, src, 1'b0, smp};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  task automatic cfg(input logic [15:0] d);
    rd(ADDR_CTL, v);
    chk(v & 16'h0400, 16'h0000);
    wr(ADDR_CFG, d);
  endtask
  task automatic sstart();
    wr(ADDR_CTL, 16'h0001);
    wr(ADDR_CTL, 16'h0003);
  endtask
  task automatic idle();
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 3000 && busy_q !== 1'b0; i++) @(posedge clk_sys);
    #1 chk({15'h0000, busy_q}, 16'h0000);
  endtask
  task automatic pulse_gap(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task print_verdict();
    $display("counts: %0d compares, %0d mismatches", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (30000) @(posedge clk_sys);
    failures++;
    print_verdict();
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
    rchk(ADDR_TRG, 16'h0007);
    rchk(ADDR_CFG, 16'h0000);
    rchk(ADDR_INTF, 16'h0000);
    rchk(ADDR_INTE, 16'h0000);
    for (int m = 0; m < 8; m++) rchk(ADDR_RES_BASE + m[3:0], 16'h0000);
    rchk(4'h5, 16'h0000);
    wr(ADDR_TRG, 16'hFFFF);
    rchk(ADDR_TRG, 16'h3FF7);
    wr(4'h5, 16'hFFFF);
    rchk(4'h5, 16'h0000);
    cfg(16'hFFFF);
    rchk(ADDR_CFG, 16'h0003);
    $display("test reset_and_reserved done");
    cfg(16'h0000);
    wr(ADDR_TRG, trg(3'h4, 3'h2, 1'b0, 1'b0, SRC_SOFT, 3'h3));
    sstart();
    pulse_gap(20);
    chk({15'h0000, busy_q}, 16'h0000);
    cfg({14'h0000, RANGE_ON});
    sstart();
    idle();
    chk({12'h000, ticks_q}, 16'h0007);
    rchk(ADDR_CTL, 16'h4003);
    for (int m = 2; m < 5; m++) rchk(ADDR_RES_BASE + m[3:0], {4'h0, res(m)});
    rchk(ADDR_INTF, 16'h001C);
    wr(ADDR_TRG, trg(3'h4, 3'h2, 1'b1, 1'b0, SRC_SOFT, 3'h3));
    rchk(4'hA, {res(2), 4'h0});
    wr(ADDR_TRG, trg(3'h4, 3'h2, 1'b0, 1'b0, SRC_SOFT, 3'h3));
    rchk(4'hA, {4'h0, res(2)});
    $display("test single_pass_align done");
    wr(ADDR_INTF, 16'h0004);
    rchk(ADDR_INTF, 16'h0018);
    wr(ADDR_INTF, 16'h0000);
    rchk(ADDR_INTF, 16'h0018);
    sstart();
    idle();
    rchk(ADDR_INTF, 16'h181C);
    rchk(4'hC, {4'h0, res(4)});
    chk({15'h0000, irq_q}, 16'h0000);
    wr(ADDR_INTE, 16'h0800);
    rchk(ADDR_INTE, 16'h0800);
    chk({15'h0000, irq_q}, 16'h0001);
    wr(ADDR_INTF, 16'h0800);
    pulse_gap(2);
    chk({15'h0000, irq_q}, 16'h0000);
    wr(ADDR_INTE, 16'h0000);
    $display("test flags_irq done");
    // slow answers from the core from here on
    slow <= 1'b1;
    wr(ADDR_INTF, 16'hFFFF);
    wr(ADDR_TRG, trg(3'h6, 3'h6, 1'b0, 1'b0, 2'h2, 3'h0));
    sstart();
    pulse_gap(20);
    chk({15'h0000, busy_q}, 16'h0000);
    wr(ADDR_TRG, trg(3'h6, 3'h6, 1'b0, 1'b0, SRC_TIMER, 3'h0));
    @(posedge clk_sys);
    timer_underflow <= 1'b1;
    @(posedge clk_sys);
    timer_underflow <= 1'b0;
    idle();
    rchk(4'hE, {4'h0, res(6)});
    wr(ADDR_TRG, trg(3'h5, 3'h5, 1'b0, 1'b1, SRC_EXT, 3'h0));
    @(posedge clk_sys);
    ext_trigger_pin_n <= 1'b0;
    @(posedge clk_sys);
    ext_trigger_pin_n <= 1'b1;
    pulse_gap(150);
    chk({15'h0000, busy_q}, 16'h0001);
    rchk(ADDR_INTF, 16'h2060);
    wr(ADDR_CTL, 16'h0001);
    idle();
    $display("test trigger_sources done");
    print_verdict();
  end
endmodule // tb_adc_config_irq_result_regs
